// file: shared/tsc_pkg.sv
// Constants and types shared by the time stamp correction calculator
package tsc_pkg;
  // Data widths
  localparam int SEC_W = 48;
  localparam int NS_W = 32;
  localparam int TS_W = SEC_W + NS_W;
  localparam int CF_W = 64;
  localparam int LAT_W = 32;
  localparam int VLAT_W = 16;
  localparam int ASYM_W = 32;
  localparam int MSG_W = 4;
  localparam int CF_FRAC_BITS = 16;

  // One second expressed in nanoseconds
  localparam logic [NS_W-1:0] NS_PER_SEC = 32'h3b9aca00;
  localparam logic [CF_W-1:0] NS_PER_SEC_64 = 64'h0000_0000_3b9a_ca00;

  // PTP message types below this value are event messages
  localparam logic [MSG_W-1:0] EVENT_MSG_LIMIT = 4'h4;

  // Reset values of the software-programmed shadows
  localparam logic [LAT_W-1:0] LOCAL_LAT_RST = 32'h0000_0000;
  localparam logic [LAT_W-1:0] LINK_DELAY_RST = 32'h0000_0000;
  localparam logic [ASYM_W-1:0] ASYM_RST = 32'h0000_0000;

  // Operation selected by the per-frame command code
  typedef enum logic [2:0] {
    TSC_CMD_NOP        = 3'b000,
    TSC_CMD_WRITE_TS   = 3'b001,
    TSC_CMD_SUB_CF     = 3'b010,
    TSC_CMD_ADD_CF     = 3'b011,
    TSC_CMD_SUB_CF_P2P = 3'b100,
    TSC_CMD_WRITE_CF   = 3'b101
  } tsc_cmd_t;
endpackage : tsc_pkg

// file: hdl/tsc_add_sub.sv
// Parameterised two's complement adder / subtractor
`timescale 1ns/1ps
`default_nettype none
module tsc_add_sub #(
  parameter int W = 64
) (
  // Operands
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic sub_i,
  // Result, wraps modulo two to the W
  output logic [W-1:0] y_o
);
  // Signed and unsigned sums are the same bit pattern
  always_comb begin
    if (sub_i) begin
      y_o = a_i - b_i;
    end else begin
      y_o = a_i + b_i;
    end
  end
endmodule : tsc_add_sub
`default_nettype wire

// file: hdl/tsc_shadow_reg.sv
// Shadow copy of one software-programmed value
`timescale 1ns/1ps
`default_nettype none
module tsc_shadow_reg #(
  parameter int W = 32,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Load strobe and live value
  input wire logic load_i,
  input wire logic [W-1:0] d_i,
  // Stable copy used by the arithmetic
  output logic [W-1:0] q_o
);
  // Copy only when told, so a half-written value never reaches a frame
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q_o <= RST_VAL;
    end else if (load_i) begin
      q_o <= d_i;
    end
  end
endmodule : tsc_shadow_reg
`default_nettype wire

// file: hdl/tsc_stamp_calc_unit.sv
// Time stamp / correction field calculator for PTP event frames
`timescale 1ns/1ps
`default_nettype none
module tsc_stamp_calc_unit (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Software-programmed values and commit strobe
  input wire logic [tsc_pkg::LAT_W-1:0] local_latency_i,
  input wire logic [tsc_pkg::LAT_W-1:0] link_delay_i,
  input wire logic [tsc_pkg::ASYM_W-1:0] asym_offset_i,
  input wire logic prog_update_i,
  input wire logic egress_dir_i,
  // Frame from the analyzer
  input wire logic frame_start_marker_i,
  input wire logic [tsc_pkg::TS_W-1:0] raw_time_i,
  input wire logic [tsc_pkg::VLAT_W-1:0] var_latency_i,
  input wire logic [2:0] cmd_i,
  input wire logic [tsc_pkg::MSG_W-1:0] msg_type_i,
  input wire logic [tsc_pkg::CF_W-1:0] cf_in_i,
  input wire logic asym_add_i,
  input wire logic asym_sub_i,
  // Result to the rewriter
  output logic result_valid_o,
  output logic result_is_cf_o,
  output logic result_modify_o,
  output logic [tsc_pkg::TS_W-1:0] new_time_o,
  output logic [tsc_pkg::CF_W-1:0] new_cf_o,
  // Derived times
  output logic [tsc_pkg::CF_W-1:0] corrected_time_nanos_o,
  output logic [tsc_pkg::CF_W-1:0] corrected_time_nanos_plus_link_o,
  // Shadow state
  output logic shadow_pending_o
);
  import tsc_pkg::*;

  logic [LAT_W-1:0] local_sh;
  logic [LAT_W-1:0] link_sh;
  logic [ASYM_W-1:0] asym_sh;
  logic pending;
  logic pipe_busy;
  logic shadow_load;

  // Stage 1: corrected local time
  logic s1_valid;
  logic [SEC_W-1:0] s1_sec;
  logic [NS_W-1:0] s1_ns;
  tsc_cmd_t s1_cmd;
  logic s1_event;
  logic [CF_W-1:0] s1_cf;
  logic s1_add;
  logic s1_sub;

  // Stage 2: nanosecond forms
  logic s2_valid;
  logic [TS_W-1:0] s2_time;
  tsc_cmd_t s2_cmd;
  logic s2_event;
  logic [CF_W-1:0] s2_cf;
  logic s2_add;
  logic s2_sub;
  logic [CF_W-1:0] s2_nanos;
  logic [CF_W-1:0] s2_nanos_link;
  logic [CF_W-1:0] s2_nanos_p2p;

  // Stage 3: command result before asymmetry
  logic s3_valid;
  logic [TS_W-1:0] s3_time;
  logic s3_is_cf;
  logic s3_modify;
  logic [CF_W-1:0] s3_cf;
  logic s3_add;
  logic s3_sub;

  // Combinational intermediates
  logic [LAT_W:0] lat_sum;
  logic [NS_W+1:0] ns_raw_ext;
  logic [NS_W+1:0] ns_calc;
  logic [NS_W-1:0] next_ns;
  logic [SEC_W-1:0] next_sec;
  logic [CF_W-1:0] sec_ext;
  logic [CF_W-1:0] nanos_now;
  logic [CF_W-1:0] link_ext;
  logic [CF_W-1:0] cmd_b;
  logic cmd_sub;
  logic [CF_W-1:0] cmd_cf;
  logic [CF_W-1:0] asym_b;
  logic [CF_W-1:0] final_cf;

  // Programmed values are copied only with no frame in flight
  assign pipe_busy = frame_start_marker_i | s1_valid | s2_valid | s3_valid;
  assign shadow_load = pending & ~pipe_busy;
  assign shadow_pending_o = pending;

  // A commit that lands during a frame waits; a new commit wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pending <= 1'b0;
    end else if (prog_update_i) begin
      pending <= 1'b1;
    end else if (shadow_load) begin
      pending <= 1'b0;
    end
  end

  // Shadow copies of fixed latency, link delay and asymmetry
  tsc_shadow_reg #(.W(LAT_W), .RST_VAL(LOCAL_LAT_RST)) u_local_sh (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(shadow_load),
    .d_i(local_latency_i),
    .q_o(local_sh)
  );
  tsc_shadow_reg #(.W(LAT_W), .RST_VAL(LINK_DELAY_RST)) u_link_sh (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(shadow_load),
    .d_i(link_delay_i),
    .q_o(link_sh)
  );
  tsc_shadow_reg #(.W(ASYM_W), .RST_VAL(ASYM_RST)) u_asym_sh (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(shadow_load),
    .d_i(asym_offset_i),
    .q_o(asym_sh)
  );

  // Total latency, then correct the nanosecond field with a carry into or a borrow from seconds.
  // Total latency is assumed below one second, so one wrap step is enough.
  always_comb begin
    lat_sum = {1'b0, local_sh} + {{(LAT_W+1-VLAT_W){1'b0}}, var_latency_i};
    ns_raw_ext = {2'b00, raw_time_i[NS_W-1:0]};
    next_sec = raw_time_i[TS_W-1:NS_W];
    if (egress_dir_i) begin
      ns_calc = ns_raw_ext + {1'b0, lat_sum};
      if (ns_calc >= {2'b00, NS_PER_SEC}) begin
        ns_calc = ns_calc - {2'b00, NS_PER_SEC};
        next_sec = next_sec + 48'h0000_0000_0001;
      end
    end else begin
      ns_calc = ns_raw_ext - {1'b0, lat_sum};
      if (ns_calc[NS_W+1]) begin
        ns_calc = ns_calc + {2'b00, NS_PER_SEC};
        next_sec = next_sec - 48'h0000_0000_0001;
      end
    end
    next_ns = ns_calc[NS_W-1:0];
  end

  // Stage 1 register; commands outside the known set act as no operation
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_valid <= 1'b0;
      s1_sec <= '0;
      s1_ns <= '0;
      s1_cmd <= TSC_CMD_NOP;
      s1_event <= 1'b0;
      s1_cf <= '0;
      s1_add <= 1'b0;
      s1_sub <= 1'b0;
    end else begin
      s1_valid <= frame_start_marker_i;
      if (frame_start_marker_i) begin
        s1_sec <= next_sec;
        s1_ns <= next_ns;
        s1_cmd <= (cmd_i > 3'b101) ? TSC_CMD_NOP : tsc_cmd_t'(cmd_i);
        s1_event <= (msg_type_i < EVENT_MSG_LIMIT);
        s1_cf <= cf_in_i;
        s1_add <= asym_add_i;
        s1_sub <= asym_sub_i;
      end
    end
  end

  // Time converted to plain nanoseconds, the multiply wraps at 64 bits
  always_comb begin
    sec_ext = {{(CF_W-SEC_W){1'b0}}, s1_sec};
    nanos_now = CF_W'(sec_ext * NS_PER_SEC_64) + {{(CF_W-NS_W){1'b0}}, s1_ns};
    link_ext = {{(CF_W-LAT_W){1'b0}}, link_sh};
  end

  // Stage 2 register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s2_valid <= 1'b0;
      s2_time <= '0;
      s2_cmd <= TSC_CMD_NOP;
      s2_event <= 1'b0;
      s2_cf <= '0;
      s2_add <= 1'b0;
      s2_sub <= 1'b0;
      s2_nanos <= '0;
      s2_nanos_link <= '0;
      s2_nanos_p2p <= '0;
    end else begin
      s2_valid <= s1_valid;
      if (s1_valid) begin
        s2_time <= {s1_sec, s1_ns};
        s2_cmd <= s1_cmd;
        s2_event <= s1_event;
        s2_cf <= s1_cf;
        s2_add <= s1_add;
        s2_sub <= s1_sub;
        s2_nanos <= nanos_now;
        s2_nanos_link <= nanos_now + link_ext;
        s2_nanos_p2p <= nanos_now - link_ext;
      end
    end
  end

  // Derived times stand until the next frame
  assign corrected_time_nanos_o = s2_nanos;
  assign corrected_time_nanos_plus_link_o = s2_nanos_link;

  // Command operand, scaled to correction field units
  always_comb begin
    cmd_b = '0;
    cmd_sub = 1'b0;
    case (s2_cmd)
      TSC_CMD_SUB_CF: begin
        cmd_b = s2_nanos << CF_FRAC_BITS;
        cmd_sub = 1'b1;
      end
      TSC_CMD_ADD_CF: begin
        cmd_b = s2_nanos << CF_FRAC_BITS;
      end
      TSC_CMD_SUB_CF_P2P: begin
        cmd_b = s2_nanos_p2p << CF_FRAC_BITS;
        cmd_sub = 1'b1;
      end
      default: begin
        cmd_b = '0;
      end
    endcase
  end

  tsc_add_sub #(.W(CF_W)) u_cmd_arith (
    .a_i(s2_cf),
    .b_i(cmd_b),
    .sub_i(cmd_sub),
    .y_o(cmd_cf)
  );

  // Stage 3 register; non-event messages keep their incoming field
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s3_valid <= 1'b0;
      s3_time <= '0;
      s3_is_cf <= 1'b0;
      s3_modify <= 1'b0;
      s3_cf <= '0;
      s3_add <= 1'b0;
      s3_sub <= 1'b0;
    end else begin
      s3_valid <= s2_valid;
      if (s2_valid) begin
        s3_time <= s2_time;
        s3_is_cf <= (s2_cmd != TSC_CMD_WRITE_TS);
        s3_modify <= s2_event & (s2_cmd != TSC_CMD_NOP);
        s3_add <= s2_add & s2_event;
        s3_sub <= s2_sub & s2_event;
        if (!s2_event) begin
          s3_cf <= s2_cf;
        end else if (s2_cmd == TSC_CMD_WRITE_CF) begin
          s3_cf <= s2_nanos << CF_FRAC_BITS;
        end else begin
          s3_cf <= cmd_cf;
        end
      end
    end
  end

  // Sign-extended asymmetry; add wins if software sets both controls
  always_comb begin
    if (s3_add | s3_sub) begin
      asym_b = {{(CF_W-ASYM_W){asym_sh[ASYM_W-1]}}, asym_sh};
    end else begin
      asym_b = '0;
    end
  end

  tsc_add_sub #(.W(CF_W)) u_asym_arith (
    .a_i(s3_cf),
    .b_i(asym_b),
    .sub_i(s3_sub & ~s3_add),
    .y_o(final_cf)
  );

  // Output register toward the rewriter
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      result_valid_o <= 1'b0;
      result_is_cf_o <= 1'b0;
      result_modify_o <= 1'b0;
      new_time_o <= '0;
      new_cf_o <= '0;
    end else begin
      result_valid_o <= s3_valid;
      if (s3_valid) begin
        result_is_cf_o <= s3_is_cf;
        result_modify_o <= s3_modify;
        new_time_o <= s3_time;
        new_cf_o <= s3_modify ? final_cf : s3_cf;
      end
    end
  end
endmodule : tsc_stamp_calc_unit
`default_nettype wire

// file: dv/tsc_checker.sv
// Concurrent checks on the calculator ports
`timescale 1ns/1ps
`default_nettype none
module tsc_checker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic prog_update_i,
  input wire logic frame_start_marker_i,
  input wire logic [2:0] cmd_i,
  input wire logic [3:0] msg_type_i,
  input wire logic [63:0] cf_in_i,
  input wire logic result_valid_o,
  input wire logic result_is_cf_o,
  input wire logic result_modify_o,
  input wire logic [63:0] new_cf_o,
  input wire logic [63:0] corrected_time_nanos_o,
  input wire logic shadow_pending_o
);
  import tsc_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Event frame with a command that rewrites something
  sequence s_event_op;
    frame_start_marker_i && msg_type_i < EVENT_MSG_LIMIT && cmd_i inside {[3'h1:3'h5]};
  endsequence
  // Commit that lands in the same cycle as a frame start
  sequence s_commit_busy;
    prog_update_i && frame_start_marker_i;
  endsequence
  a_result_latency: assert property (frame_start_marker_i |-> ##4 result_valid_o)
    else $error("result pulse missing");
  a_no_stray_result: assert property (result_valid_o |-> $past(frame_start_marker_i, 4))
    else $error("result without frame");
  a_event_modify: assert property (s_event_op |-> ##4 result_modify_o)
    else $error("event frame not modified");
  a_cf_select: assert property (s_event_op |-> ##4 result_is_cf_o == ($past(cmd_i, 4) != TSC_CMD_WRITE_TS))
    else $error("wrong result kind");
  a_nonevent_pass: assert property (frame_start_marker_i && msg_type_i >= EVENT_MSG_LIMIT
    |-> ##4 !result_modify_o && new_cf_o == $past(cf_in_i, 4)) else $error("non-event frame altered");
  a_nop_passes: assert property (frame_start_marker_i && !(cmd_i inside {[3'h1:3'h5]})
    |-> ##4 !result_modify_o) else $error("no-op command modified");
  a_nanos_timing: assert property ($changed(corrected_time_nanos_o) |-> $past(frame_start_marker_i, 2))
    else $error("nanos changed off frame");
  a_commit_defer: assert property (s_commit_busy |=> shadow_pending_o [*3])
    else $error("shadow loaded mid frame");
  a_commit_lands: assert property ((shadow_pending_o && !frame_start_marker_i && !prog_update_i) [*4]
    |=> !shadow_pending_o) else $error("shadow load stuck");
endmodule : tsc_checker
bind tsc_stamp_calc_unit tsc_checker u_chk (.core_clk_i, .rst_i, .prog_update_i, .frame_start_marker_i, .cmd_i,
  .msg_type_i, .cf_in_i, .result_valid_o, .result_is_cf_o, .result_modify_o, .new_cf_o, .corrected_time_nanos_o,
  .shadow_pending_o);
`default_nettype wire

// file: dv/tsc_far_side_model.sv
// Latency predictor and rewriter stand-in
`timescale 1ns/1ps
`default_nettype none
module tsc_far_side_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Pipeline fill seen by the predictor
  input wire logic [15:0] depth_i,
  output logic [15:0] var_latency_o,
  // Result path
  input wire logic result_valid_i,
  input wire logic [63:0] cf_i,
  output logic [63:0] cf_o,
  output logic [7:0] count_o
);
  // Prediction follows the pipeline state each cycle
  assign var_latency_o = depth_i;
  // Rewriter takes the field only on the pulse, so a late pulse shows as a stale capture
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_o <= 8'h00;
    end else if (result_valid_i) begin
      cf_o <= cf_i;
      count_o <= count_o + 8'h01;
    end
  end
endmodule : tsc_far_side_model
`default_nettype wire

// file: dv/tsc_stamp_calc_unit_tb_top.sv
// Self-checking bench for the time stamp calculator
`timescale 1ns/1ps
`default_nettype none
module tsc_stamp_calc_unit_tb_top;
  import tsc_pkg::*;
  logic core_clk_i = 1'b0, rst_i = 1'b1, prog_update_i = 1'b0, egress_dir_i = 1'b0, frame_start_marker_i = 1'b0;
  logic asym_add_i = 1'b0, asym_sub_i = 1'b0, result_valid_o, result_is_cf_o, result_modify_o, shadow_pending_o;
  logic [31:0] local_latency_i = 32'h64, link_delay_i = 32'h32, asym_offset_i = 32'hfffe_8000;
  logic [31:0] sl = LOCAL_LAT_RST, sk = LINK_DELAY_RST, sa = ASYM_RST;
  logic [79:0] raw_time_i = 80'h0, new_time_o;
  logic [15:0] depth = 16'h0, var_latency_i;
  logic [2:0] cmd_i = 3'h0;
  logic [3:0] msg_type_i = 4'h0;
  logic [63:0] cf_in_i = 64'h0, new_cf_o, seen_cf, corrected_time_nanos_o, corrected_time_nanos_plus_link_o;
  logic [7:0] seen_cnt;
  int fail_count = 0, total_checks = 0;
  // Free-running 25 MHz clock
  always #20 core_clk_i = ~core_clk_i;
  tsc_stamp_calc_unit dut (.core_clk_i, .rst_i, .local_latency_i, .link_delay_i, .asym_offset_i, .prog_update_i,
    .egress_dir_i, .frame_start_marker_i, .raw_time_i, .var_latency_i, .cmd_i, .msg_type_i, .cf_in_i, .asym_add_i,
    .asym_sub_i, .result_valid_o, .result_is_cf_o, .result_modify_o, .new_time_o, .new_cf_o, .corrected_time_nanos_o,
    .corrected_time_nanos_plus_link_o, .shadow_pending_o);
  tsc_far_side_model far (.core_clk_i, .rst_i, .depth_i(depth), .var_latency_o(var_latency_i),
    .result_valid_i(result_valid_o), .cf_i(new_cf_o), .cf_o(seen_cf), .count_o(seen_cnt));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Mode bits: 0 egress, 1 asym add, 2 asym sub, 3 commit with the frame
  task automatic fr(input logic [3:0] md, input logic [2:0] c, input logic [3:0] m, input logic [79:0] rt,
                    input logic [15:0] v, input logic [63:0] cf);
    logic [47:0] s;
    logic [31:0] ns, t;
    logic [63:0] nn, e;
    logic [7:0] n;
    logic ev;
    s = rt[79:32];
    t = sl + 32'(v);
    ns = md[0] ? rt[31:0] + t : rt[31:0] - t;
    if (md[0] && ns >= NS_PER_SEC) begin
      ns = ns - NS_PER_SEC;
      s = s + 48'h1;
    end else if (!md[0] && rt[31:0] < t) begin
      ns = ns + NS_PER_SEC;
      s = s - 48'h1;
    end
    nn = {16'h0, s} * NS_PER_SEC_64 + 64'(ns);
    case (c)
      3'h2: e = cf - (nn << 16);
      3'h3: e = cf + (nn << 16);
      3'h4: e = cf - ((nn - 64'(sk)) << 16);
      3'h5: e = nn << 16;
      default: e = cf;
    endcase
    // Add wins when both asymmetry controls are set
    if (md[1]) e = e + {{32{sa[31]}}, sa};
    else if (md[2]) e = e - {{32{sa[31]}}, sa};
    ev = m < EVENT_MSG_LIMIT && c inside {[3'h1:3'h5]};
    if (!ev) e = cf;
    @(posedge core_clk_i);
    {prog_update_i, asym_sub_i, asym_add_i, egress_dir_i, cmd_i, msg_type_i} <= {md, c, m};
    raw_time_i <= rt;
    depth <= v;
    cf_in_i <= cf;
    frame_start_marker_i <= 1'b1;
    @(posedge core_clk_i);
    frame_start_marker_i <= 1'b0;
    prog_update_i <= 1'b0;
    n = seen_cnt;
    for (int i = 0; i < 8 && seen_cnt == n; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    if (seen_cnt == n) begin
      fail_count++;
      report_and_stop();
    end
    chk("nanos", 80'(nn), 80'(corrected_time_nanos_o));
    chk("nanos_link", 80'(nn + 64'(sk)), 80'(corrected_time_nanos_plus_link_o));
    chk("modify", 80'(ev), 80'(result_modify_o));
    if (c == TSC_CMD_WRITE_TS) chk("time", {s, ns}, new_time_o);
    else chk("cf", 80'(e), 80'(seen_cf));
    if (md[3]) begin
      sl = local_latency_i;
      sk = link_delay_i;
      sa = asym_offset_i;
    end
  endtask : fr
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // Live inputs are set but not committed, so reset shadows apply
    fr(4'h0, TSC_CMD_WRITE_CF, 4'h0, {48'h5, 32'h10}, 16'h0, 64'h0);
    fr(4'h8, TSC_CMD_NOP, 4'h0, {48'h5, 32'h10}, 16'h0, 64'h77);
    $display("test shadow_reset done");
    fr(4'h0, TSC_CMD_WRITE_TS, 4'h0, {48'h7, 32'h14}, 16'h1e, 64'h0);
    fr(4'h1, TSC_CMD_WRITE_TS, 4'h1, {48'h7, 32'h3b9a_c9ec}, 16'h1e, 64'h0);
    fr(4'h0, TSC_CMD_SUB_CF, 4'h2, {48'h1, 32'h1000}, 16'h8, 64'h1234_5678_0000);
    fr(4'h1, TSC_CMD_ADD_CF, 4'h3, {48'h1, 32'h1000}, 16'h8, 64'hffff_ffff_ffff_0000);
    fr(4'h0, TSC_CMD_SUB_CF_P2P, 4'h0, {48'h2, 32'h500}, 16'h4, 64'h100_0000_0000);
    fr(4'h3, TSC_CMD_WRITE_CF, 4'h0, {48'h0, 32'h2000}, 16'h2, 64'h0);
    fr(4'h4, TSC_CMD_ADD_CF, 4'h0, {48'h0, 32'h2000}, 16'h2, 64'h10_0000);
    // Both controls set by mistake: the add path is expected to win
    fr(4'h6, TSC_CMD_ADD_CF, 4'h1, {48'h0, 32'h2000}, 16'h2, 64'h10_0000);
    fr(4'h2, TSC_CMD_SUB_CF, 4'h8, {48'h3, 32'h0}, 16'h2, 64'habcd_0000);
    for (int k = 6; k < 8; k++) fr(4'h0, 3'(k), 4'h0, {48'h3, 32'h0}, 16'h2, 64'h5);
    $display("test arith done");
    // Commit lands with a frame, which must still use the old copies
    // Realign to the rising edge so the new live values change on it
    @(posedge core_clk_i);
    local_latency_i <= 32'hc8;
    link_delay_i <= 32'h10;
    asym_offset_i <= 32'h1_0000;
    fr(4'ha, TSC_CMD_SUB_CF_P2P, 4'h0, {48'h4, 32'h100}, 16'h1, 64'h0);
    fr(4'h2, TSC_CMD_SUB_CF_P2P, 4'h0, {48'h4, 32'h100}, 16'h1, 64'h0);
    $display("test shadow_hold done");
    report_and_stop();
  end
endmodule : tsc_stamp_calc_unit_tb_top
`default_nettype wire
